// ---- inc/scw_pkg.sv ----
package scw_pkg;

    // ------------------------------------------------------------
    // register word addresses (data memory word numbers)
    // ------------------------------------------------------------
    localparam logic [15:0] SERIAL_PORT_SERVICE_TIME_ADDR     = 16'h19D8;
    localparam logic [15:0] PERIPHERAL_PORT_SERVICE_TIME_ADDR = 16'h19D9;
    localparam logic [15:0] MINIMUM_SCAN_TIME_ADDR            = 16'h19DB;
    localparam logic [15:0] INPUT_SETTLING_SELECT_ADDR        = 16'h19DC;
    localparam logic [15:0] FAST_TIMER_IRQ_COUNT_ADDR         = 16'h19E5;
    localparam logic [15:0] DIGIT_READ_AND_REFRESH_ADDR       = 16'h19EF;

    // ------------------------------------------------------------
    // field layout and reset values
    // ------------------------------------------------------------
    localparam int          ENABLE_MSB     = 15;
    localparam int          ENABLE_LSB     = 8;
    localparam int          VALUE_MSB      = 7;
    localparam int          VALUE_LSB      = 0;
    localparam logic [7:0]  ENABLE_OFF     = 8'h00;
    localparam logic [7:0]  ENABLE_ON      = 8'h01;
    localparam logic [15:0] SERVICE_RESET  = 16'h0000;
    localparam logic [15:0] MIN_SCAN_RESET = 16'h0000;
    localparam logic [15:0] SETTLE_RESET   = 16'h0000;
    localparam logic [15:0] FAST_RESET     = 16'h0000;
    localparam logic [15:0] DIGIT_RESET    = 16'h0000;
    localparam logic [7:0]  DEFAULT_PCT    = 8'h05;
    localparam logic [4:0]  ALL_FAST_TIMERS = 5'd16;
    localparam logic [3:0]  SETTLE_DEFAULT = 4'h0;
    localparam int          SETTLE_MAX_CODE = 8;
    localparam int          FAST_MAX_COUNT = 15;

    // ------------------------------------------------------------
    // error codes
    // ------------------------------------------------------------
    localparam logic [7:0]  SETUP_ERROR_CODE = 8'h9B;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ         = 100;
    localparam int TICK_US         = 1000;
    localparam int TICK_CYCLES     = TICK_US * CLK_MHZ;
    localparam int MIN_SERVICE_NS  = 340;   // 0.34 ms in us below
    localparam int MIN_SERVICE_US  = 340;
    localparam int MIN_SERVICE_CYCLES = MIN_SERVICE_US * CLK_MHZ;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic        wrEn;
        logic [15:0] addr;
        logic [15:0] wrData;
    } scw_bus_type;

    typedef struct packed {
        logic [6:0] serialPct;
        logic [6:0] periphPct;
        logic [13:0] minScanMs;
        logic [3:0] settleLo;
        logic [3:0] settleHi;
        logic [4:0] fastTimers;
        logic       eightDigits;
        logic       directRefresh;
    } scw_setup_type;

    typedef enum logic [2:0] {
        SCAN_RUN   = 3'b001,
        SCAN_WAIT  = 3'b010,
        SCAN_IDLE  = 3'b100
    } scw_scan_state_type;

    // two-digit bcd to binary
    function automatic logic [6:0] bcd2(input logic [7:0] v);
        bcd2 = (7'(v[7:4]) * 7'd10) + 7'(v[3:0]);
    endfunction

    function automatic logic bcdOk(input logic [3:0] d);
        bcdOk = (d <= 4'd9);
    endfunction

endpackage

// ---- rtl/scw_settle_filter.sv ----
`timescale 1ns/10ps
// input settling filter for one group of eight inputs
module scw_settle_filter
    import scw_pkg::*;
#(
    parameter int WIDTH    = 8,
    parameter int CNT_BITS = 8
) (
    // clock and reset
    input  wire logic                core_clk,
    input  wire logic                srst,
    // timing
    input  wire logic                msTick,
    input  wire logic [CNT_BITS-1:0] settleMs,
    // data
    input  wire logic [WIDTH-1:0]    rawIn,
    output logic      [WIDTH-1:0]    filtered
);
    initial begin
        if (WIDTH < 1 || CNT_BITS < 8) $error("scw_settle_filter: bad parameters");
    end

    logic [CNT_BITS-1:0] count_reg [WIDTH];

    // -----------------------------------------------------------
    // per-bit stability counter
    // -----------------------------------------------------------
    // a bit only follows the pin once it held steady for the whole time
    always_ff @(posedge core_clk) begin
        for (int i = 0; i < WIDTH; i++) begin
            if (srst) begin
                count_reg[i] <= '0;
                filtered[i]  <= 1'b0;
            end else if (rawIn[i] == filtered[i]) begin
                count_reg[i] <= '0;
            end else if (msTick) begin
                if (count_reg[i] + 1'b1 >= settleMs) begin
                    filtered[i]  <= rawIn[i];
                    count_reg[i] <= '0;
                end else begin
                    count_reg[i] <= count_reg[i] + 1'b1;
                end
            end
        end
    end
endmodule

// ---- rtl/scw_setup_words.sv ----
`timescale 1ns/10ps
module scw_setup_words
    import scw_pkg::*;
#(
    parameter int TICK_COUNT    = TICK_CYCLES,
    parameter int MIN_SVC_COUNT = MIN_SERVICE_CYCLES
) (
    // clock and reset
    input  wire logic          core_clk,
    input  wire logic          srst,
    // setup word access port
    input  wire scw_bus_type   bus,
    output logic [15:0]        rdData,
    // mode events
    input  wire logic          programStart,
    input  wire logic          programStop,
    input  wire logic          progToMonitor,
    input  wire logic          forced_state_retain_flag,
    input  wire logic          io_memory_retain_flag,
    // scan control
    input  wire logic          scanDone,
    output logic               scanStart,
    output logic               min_cycle_overrun_flag,
    output logic [15:0]        lastScanMs,
    // port service
    input  wire logic          serialReq,
    input  wire logic          periphReq,
    output logic               serialSvc,
    output logic               periphSvc,
    // inputs
    input  wire logic [15:0]   rawInputs,
    output logic [15:0]        settledInputs,
    // retain controls
    output logic               clearForced,
    output logic               clearIoArea,
    // active setup
    output scw_setup_type      active,
    output logic               setupError,
    output logic [7:0]         errorCode,
    output logic [2:0]         setupErrFlags
);
    initial begin
        if (TICK_COUNT < 1 || MIN_SVC_COUNT < 1) $error("scw_setup_words: bad counts");
    end

    // -----------------------------------------------------------
    // setup word storage
    // -----------------------------------------------------------
    logic [15:0] serialWord_reg, periphWord_reg, minScan_reg;
    logic [15:0] settle_reg, fast_reg, digit_reg;

    // words written through the port; decoded values only latched at program start
    always_ff @(posedge core_clk) begin
        if (srst) begin
            serialWord_reg <= SERVICE_RESET;
            periphWord_reg <= SERVICE_RESET;
            minScan_reg    <= MIN_SCAN_RESET;
            settle_reg     <= SETTLE_RESET;
            fast_reg       <= FAST_RESET;
            digit_reg      <= DIGIT_RESET;
        end else if (bus.wrEn) begin
            if (bus.addr == SERIAL_PORT_SERVICE_TIME_ADDR) begin
                serialWord_reg <= bus.wrData;
            end else if (bus.addr == PERIPHERAL_PORT_SERVICE_TIME_ADDR) begin
                periphWord_reg <= bus.wrData;
            end else if (bus.addr == MINIMUM_SCAN_TIME_ADDR) begin
                minScan_reg <= bus.wrData;
            end else if (bus.addr == INPUT_SETTLING_SELECT_ADDR) begin
                settle_reg <= bus.wrData;
            end else if (bus.addr == FAST_TIMER_IRQ_COUNT_ADDR) begin
                fast_reg <= bus.wrData;
            end else if (bus.addr == DIGIT_READ_AND_REFRESH_ADDR) begin
                digit_reg <= bus.wrData;
            end
        end
    end

    // read mux; unmapped words read zero
    always_comb begin
        if (bus.addr == SERIAL_PORT_SERVICE_TIME_ADDR) begin
            rdData = serialWord_reg;
        end else if (bus.addr == PERIPHERAL_PORT_SERVICE_TIME_ADDR) begin
            rdData = periphWord_reg;
        end else if (bus.addr == MINIMUM_SCAN_TIME_ADDR) begin
            rdData = minScan_reg;
        end else if (bus.addr == INPUT_SETTLING_SELECT_ADDR) begin
            rdData = settle_reg;
        end else if (bus.addr == FAST_TIMER_IRQ_COUNT_ADDR) begin
            rdData = fast_reg;
        end else if (bus.addr == DIGIT_READ_AND_REFRESH_ADDR) begin
            rdData = digit_reg;
        end else begin
            rdData = 16'h0000;
        end
    end

    // -----------------------------------------------------------
    // decode with validity checks
    // -----------------------------------------------------------
    function automatic logic twoBcdOk(input logic [7:0] v);
        twoBcdOk = bcdOk(v[7:4]) && bcdOk(v[3:0]);
    endfunction

    // service word: returns percentage, bad flag from svcBad
    function automatic logic [7:0] svcPct(input logic [15:0] w);
        if (w[ENABLE_MSB:ENABLE_LSB] == ENABLE_ON && twoBcdOk(w[VALUE_MSB:VALUE_LSB])) begin
            svcPct = {1'b0, bcd2(w[VALUE_MSB:VALUE_LSB])};
        end else begin
            svcPct = {1'b0, bcd2(DEFAULT_PCT)};
        end
    endfunction

    function automatic logic svcBad(input logic [15:0] w);
        svcBad = !((w[ENABLE_MSB:ENABLE_LSB] == ENABLE_OFF)
                 || (w[ENABLE_MSB:ENABLE_LSB] == ENABLE_ON && twoBcdOk(w[VALUE_MSB:VALUE_LSB])));
    endfunction

    scw_setup_type decoded;
    logic [2:0]    badBits;
    logic [6:0]    fastN;

    always_comb begin
        decoded  = '0;
        badBits  = 3'b000;
        fastN    = bcd2(fast_reg[VALUE_MSB:VALUE_LSB]);
        decoded.serialPct = 7'(svcPct(serialWord_reg));
        decoded.periphPct = 7'(svcPct(periphWord_reg));
        badBits[0] = svcBad(serialWord_reg) || svcBad(periphWord_reg);
        // four bcd digits, 0000 means variable
        if (twoBcdOk(minScan_reg[15:8]) && twoBcdOk(minScan_reg[7:0])) begin
            decoded.minScanMs = (14'(bcd2(minScan_reg[15:8])) * 14'd100) + 14'(bcd2(minScan_reg[7:0]));
        end else begin
            badBits[1] = 1'b1;
        end
        // two one-digit codes, upper byte ignored
        decoded.settleLo = SETTLE_DEFAULT;
        decoded.settleHi = SETTLE_DEFAULT;
        if (settle_reg[3:0] <= 4'(SETTLE_MAX_CODE)) decoded.settleLo = settle_reg[3:0];
        else badBits[2] = 1'b1;
        if (settle_reg[7:4] <= 4'(SETTLE_MAX_CODE)) decoded.settleHi = settle_reg[7:4];
        else badBits[2] = 1'b1;
        // fast timers counted from zero
        decoded.fastTimers = ALL_FAST_TIMERS;
        if (fast_reg[ENABLE_MSB:ENABLE_LSB] == ENABLE_ON) begin
            if (twoBcdOk(fast_reg[VALUE_MSB:VALUE_LSB]) && fastN <= 7'(FAST_MAX_COUNT)) begin
                decoded.fastTimers = fastN[4:0];
            end else begin
                badBits[2] = 1'b1;
            end
        end else if (fast_reg[ENABLE_MSB:ENABLE_LSB] != ENABLE_OFF) begin
            badBits[2] = 1'b1;
        end
        // digit count in upper byte, refresh method in lower
        if (digit_reg[15:8] == ENABLE_ON) decoded.eightDigits = 1'b1;
        else if (digit_reg[15:8] != ENABLE_OFF) badBits[2] = 1'b1;
        if (digit_reg[7:0] == ENABLE_ON) decoded.directRefresh = 1'b1;
        else if (digit_reg[7:0] != ENABLE_OFF) badBits[2] = 1'b1;
    end

    // latch at program start only, so edits mid-run wait for next start
    always_ff @(posedge core_clk) begin
        if (srst) begin
            active        <= '0;
            setupError    <= 1'b0;
            errorCode     <= 8'h00;
            setupErrFlags <= 3'b000;
        end else if (programStart) begin
            active        <= decoded;
            setupErrFlags <= badBits;
            setupError    <= |badBits;
            errorCode     <= (|badBits) ? SETUP_ERROR_CODE : 8'h00;
        end
    end

    // -----------------------------------------------------------
    // retain behaviour
    // -----------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (srst) begin
            clearForced <= 1'b0;
            clearIoArea <= 1'b0;
        end else begin
            clearForced <= progToMonitor && !forced_state_retain_flag;
            clearIoArea <= (programStart || programStop) && !io_memory_retain_flag;
        end
    end

    // -----------------------------------------------------------
    // 1 ms timebase and scan timing
    // -----------------------------------------------------------
    logic [$clog2(TICK_COUNT+1)-1:0] tick_reg;
    logic msTick;
    assign msTick = (tick_reg == ($bits(tick_reg))'(TICK_COUNT - 1));

    // free running so measurements share one phase
    always_ff @(posedge core_clk) begin
        if (srst || msTick) tick_reg <= '0;
        else tick_reg <= tick_reg + 1'b1;
    end

    scw_scan_state_type state_reg;
    logic [15:0] scanMs_reg;
    logic        running_reg;

    always_ff @(posedge core_clk) begin
        if (srst) running_reg <= 1'b0;
        else if (programStart) running_reg <= 1'b1;
        else if (programStop) running_reg <= 1'b0;
    end

    assign scanStart = running_reg && (state_reg == SCAN_IDLE);

    always_ff @(posedge core_clk) begin
        if (srst || !running_reg) begin
            state_reg <= SCAN_IDLE;
            scanMs_reg <= 16'h0000;
        end else begin
            if (msTick && scanMs_reg != 16'hFFFF) scanMs_reg <= scanMs_reg + 16'h0001;
            case (state_reg)
                SCAN_IDLE: begin
                    state_reg  <= SCAN_RUN;
                    scanMs_reg <= 16'h0000;
                end
                SCAN_RUN: begin
                    if (scanDone) begin
                        if (scanMs_reg < 16'(active.minScanMs)) state_reg <= SCAN_WAIT;
                        else state_reg <= SCAN_IDLE;
                    end
                end
                SCAN_WAIT: begin
                    if (scanMs_reg >= 16'(active.minScanMs)) state_reg <= SCAN_IDLE;
                end
                default: state_reg <= SCAN_IDLE;
            endcase
        end
    end

    // overrun sticky until next program start; set wins over clear
    always_ff @(posedge core_clk) begin
        if (srst) begin
            min_cycle_overrun_flag <= 1'b0;
            lastScanMs             <= 16'h0000;
        end else begin
            if (state_reg == SCAN_RUN && scanDone) lastScanMs <= scanMs_reg;
            if (state_reg == SCAN_RUN && scanDone && active.minScanMs != 14'd0
                && scanMs_reg > 16'(active.minScanMs)) begin
                min_cycle_overrun_flag <= 1'b1;
            end else if (programStart) begin
                min_cycle_overrun_flag <= 1'b0;
            end
        end
    end

    // -----------------------------------------------------------
    // port service slots, serial then peripheral after each scan
    // -----------------------------------------------------------
    logic [1:0]  svcPort_reg;     // 01 serial, 10 peripheral
    logic [31:0] svcCnt_reg, svcLen;
    logic [31:0] scanCycles_reg;
    logic        curReq;

    always_comb begin
        svcLen = (scanCycles_reg / 32'd100) * 32'(svcPort_reg[0] ? active.serialPct : active.periphPct);
        if (svcLen < 32'(MIN_SVC_COUNT)) svcLen = 32'(MIN_SVC_COUNT);
        curReq = svcPort_reg[0] ? serialReq : periphReq;
    end

    always_ff @(posedge core_clk) begin
        if (srst || scanStart) scanCycles_reg <= 32'h0;
        else if (state_reg == SCAN_RUN && scanCycles_reg != 32'hFFFFFFFF) scanCycles_reg <= scanCycles_reg + 32'h1;
    end

    always_ff @(posedge core_clk) begin
        if (srst || !running_reg) begin
            svcPort_reg <= 2'b00;
            svcCnt_reg  <= 32'h0;
        end else if (state_reg == SCAN_RUN && scanDone) begin
            svcPort_reg <= 2'b01;
            svcCnt_reg  <= 32'h0;
        end else if (svcPort_reg != 2'b00) begin
            if (!curReq || svcCnt_reg + 32'h1 >= svcLen) begin
                svcPort_reg <= {svcPort_reg[0], 1'b0};
                svcCnt_reg  <= 32'h0;
            end else begin
                svcCnt_reg <= svcCnt_reg + 32'h1;
            end
        end
    end

    assign serialSvc = svcPort_reg[0] && serialReq;
    assign periphSvc = svcPort_reg[1] && periphReq;

    // -----------------------------------------------------------
    // input settling
    // -----------------------------------------------------------
    function automatic logic [7:0] settleMs(input logic [3:0] code);
        case (code)
            4'h1: settleMs = 8'd1;
            4'h2: settleMs = 8'd2;
            4'h3: settleMs = 8'd4;
            4'h5: settleMs = 8'd16;
            4'h6: settleMs = 8'd32;
            4'h7: settleMs = 8'd64;
            4'h8: settleMs = 8'd128;
            default: settleMs = 8'd8;
        endcase
    endfunction

    // pins are asynchronous: two flops before any filter logic
    logic [15:0] inMeta_reg, inSync_reg;
    always_ff @(posedge core_clk) begin
        if (srst) begin
            inMeta_reg <= 16'h0000;
            inSync_reg <= 16'h0000;
        end else begin
            inMeta_reg <= rawInputs;
            inSync_reg <= inMeta_reg;
        end
    end

    scw_settle_filter #(.WIDTH(8), .CNT_BITS(8)) uLowGroup (
        .core_clk (core_clk),
        .srst     (srst),
        .msTick   (msTick),
        .settleMs (settleMs(active.settleLo)),
        .rawIn    (inSync_reg[7:0]),
        .filtered (settledInputs[7:0])
    );

    scw_settle_filter #(.WIDTH(8), .CNT_BITS(8)) uHighGroup (
        .core_clk (core_clk),
        .srst     (srst),
        .msTick   (msTick),
        .settleMs (settleMs(active.settleHi)),
        .rawIn    (inSync_reg[15:8]),
        .filtered (settledInputs[15:8])
    );
endmodule

// ---- test/scw_setup_words_checker.sv ----
`timescale 1ns/10ps
// ------------------------------------------------------------
// port-level checks on the setup word block
// ------------------------------------------------------------
module scw_setup_words_checker
    import scw_pkg::*;
(
    // clock and reset
    input wire logic          core_clk,
    input wire logic          srst,
    // events and flags
    input wire logic          programStart,
    input wire logic          programStop,
    input wire logic          progToMonitor,
    input wire logic          forced_state_retain_flag,
    input wire logic          io_memory_retain_flag,
    input wire logic          scanDone,
    input wire logic          scanStart,
    input wire logic          min_cycle_overrun_flag,
    // service and results
    input wire logic          serialReq,
    input wire logic          periphReq,
    input wire logic          serialSvc,
    input wire logic          periphSvc,
    input wire logic          clearForced,
    input wire logic          clearIoArea,
    input wire scw_setup_type active,
    input wire logic          setupError,
    input wire logic [7:0]    errorCode,
    input wire logic [2:0]    setupErrFlags
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    // setup only moves on the edge after a program start
    chk_active_latch: assert property (!$past(programStart) && !$past(srst) |-> $stable(active))
        else $error("setup changed without program start");
    chk_error_code: assert property (errorCode == (setupError ? SETUP_ERROR_CODE : 8'h00))
        else $error("error code wrong");
    chk_error_flags: assert property (setupError == (setupErrFlags != 3'h0))
        else $error("error flags disagree");
    chk_forced_clear: assert property (progToMonitor |=> clearForced == !$past(forced_state_retain_flag))
        else $error("forced state clear wrong");
    chk_io_clear: assert property ((programStart || programStop) |=> clearIoArea == !$past(io_memory_retain_flag))
        else $error("io area clear wrong");
    // a port is only shown as serviced while its request is pending
    chk_serial_req: assert property (serialSvc |-> serialReq)
        else $error("serial slot without request");
    chk_periph_req: assert property (periphSvc |-> periphReq)
        else $error("peripheral slot without request");
    chk_slot_apart: assert property (!(serialSvc && periphSvc))
        else $error("both ports serviced at once");
    chk_overrun_cause: assert property ($rose(min_cycle_overrun_flag) |-> $past(scanDone) && active.minScanMs != 0)
        else $error("overrun without long scan");
    chk_field_range: assert property (active.serialPct <= 7'd99 && active.fastTimers <= 5'd16)
        else $error("latched field out of range");
    chk_var_scan: assert property (scanDone && active.minScanMs == 14'd0 |-> ##[0:2] scanStart)
        else $error("variable scan did not restart");
endmodule

bind scw_setup_words scw_setup_words_checker chk_u (.core_clk, .srst, .programStart, .programStop,
    .progToMonitor, .forced_state_retain_flag, .io_memory_retain_flag, .scanDone, .scanStart,
    .min_cycle_overrun_flag, .serialReq, .periphReq, .serialSvc, .periphSvc, .clearForced,
    .clearIoArea, .active, .setupError, .errorCode, .setupErrFlags);

// ---- test/tb_scw_setup_words.sv ----
`timescale 1ns/10ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin mismatches++; $display("ERROR %0t bad %h", $time, a); end end
// ------------------------------------------------------------
// bench: short tick so a ms is 10 cycles
// ------------------------------------------------------------
module tb_scw_setup_words;
    import scw_pkg::*;
    logic core_clk, srst, programStart, programStop, progToMonitor, scanDone, scanStart;
    logic forced_state_retain_flag, io_memory_retain_flag, min_cycle_overrun_flag;
    logic serialReq, periphReq, serialSvc, periphSvc, clearForced, clearIoArea, setupError;
    logic [15:0] rdData, lastScanMs, rawInputs, settledInputs;
    logic [7:0] errorCode;
    logic [2:0] setupErrFlags;
    scw_bus_type bus;
    scw_setup_type active;
    int mismatches, compares, cycles, n, svc;
    logic cf, ci;

    scw_setup_words #(.TICK_COUNT(10), .MIN_SVC_COUNT(4)) dut_u (.core_clk, .srst, .bus, .rdData,
        .programStart, .programStop, .progToMonitor, .forced_state_retain_flag, .io_memory_retain_flag,
        .scanDone, .scanStart, .min_cycle_overrun_flag, .lastScanMs, .serialReq, .periphReq, .serialSvc,
        .periphSvc, .rawInputs, .settledInputs, .clearForced, .clearIoArea, .active, .setupError,
        .errorCode, .setupErrFlags);

    // free clock, 10 ns
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // hang guard, well above the longest sequence
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 2000) begin
            mismatches++;
            complete_run();
        end
    end

    task automatic complete_run();
        if (mismatches == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic tick(int k);
        repeat (k) @(negedge core_clk);
    endtask
    task automatic wr(logic [15:0] a, logic [15:0] d);
        bus = '{1'b1, a, d};
        tick(1);
        bus.wrEn = 1'b0;
        `CHK(rdData, d)
        // one idle edge so the next write never re-raises the strobe in the same step
        tick(1);
    endtask
    task automatic start();
        programStart = 1'b1;
        tick(1);
        programStart = 1'b0;
        tick(1);
    endtask
    // end a scan, then count cycles until the next one begins; svc counts serial slot cycles
    task automatic scan_end(int lim);
        scanDone = 1'b1;
        n = 0;
        #1;
        while (scanStart !== 1'b1 && n < lim) begin
            tick(1);
            scanDone = 1'b0;
            n++;
            #1;
            if (serialSvc === 1'b1) svc++;
        end
        if (n == 0) tick(1);
        scanDone = 1'b0;
    endtask

    task automatic t_latch();
        `CHK(active, '0)
        bus.addr = 16'h19DA;
        #1 `CHK(rdData, 16'h0000)
        wr(SERIAL_PORT_SERVICE_TIME_ADDR, 16'h0110);
        wr(PERIPHERAL_PORT_SERVICE_TIME_ADDR, 16'h0115);
        wr(INPUT_SETTLING_SELECT_ADDR, 16'h0031);
        wr(FAST_TIMER_IRQ_COUNT_ADDR, 16'h0108);
        `CHK(active.serialPct, 7'd0)
        start();
        `CHK(active.serialPct, 7'd10)
        `CHK(active.periphPct, 7'd15)
        `CHK({active.settleHi, active.settleLo}, 8'h31)
        `CHK(active.fastTimers, 5'd8)
        `CHK({active.eightDigits, active.directRefresh}, 2'b00)
    endtask
    task automatic t_defaults();
        wr(SERIAL_PORT_SERVICE_TIME_ADDR, 16'h0010);
        wr(FAST_TIMER_IRQ_COUNT_ADDR, 16'h0005);
        start();
        `CHK(active.serialPct, 7'd5)
        `CHK(active.fastTimers, 5'd16)
        `CHK(setupError, 1'b0)
        wr(SERIAL_PORT_SERVICE_TIME_ADDR, 16'h01A3);
        wr(FAST_TIMER_IRQ_COUNT_ADDR, 16'h0116);
        start();
        `CHK(active.serialPct, 7'd5)
        `CHK({setupError, errorCode, setupErrFlags}, {1'b1, 8'h9B, 3'b101})
    endtask
    task automatic t_retain();
        for (int i = 0; i < 2; i++) begin
            forced_state_retain_flag = i[0];
            io_memory_retain_flag = i[0];
            progToMonitor = 1'b1;
            programStop = 1'b1;
            {cf, ci} = 2'b00;
            repeat (3) begin
                tick(1);
                {progToMonitor, programStop} = 2'b00;
                cf |= clearForced;
                ci |= clearIoArea;
            end
            `CHK(cf, !i[0])
            `CHK(ci, !i[0])
        end
    endtask
    // lo group 1 ms, hi group 4 ms
    task automatic t_settle();
        rawInputs = 16'h0101;
        tick(5);
        `CHK(settledInputs[0], 1'b0)
        tick(20);
        `CHK(settledInputs[8:0], 9'h001)
        tick(35);
        `CHK(settledInputs, 16'h0101)
    endtask
    task automatic t_scan();
        wr(SERIAL_PORT_SERVICE_TIME_ADDR, 16'h0110);
        wr(FAST_TIMER_IRQ_COUNT_ADDR, 16'h0104);
        start();
        scan_end(10);
        `CHK(n <= 3, 1'b1)
        wr(MINIMUM_SCAN_TIME_ADDR, 16'h0005);
        start();
        {serialReq, periphReq} = 2'b11;
        scan_end(100);
        tick(2);
        svc = 0;
        scan_end(100);
        `CHK(n >= 30 && n <= 60, 1'b1)
        `CHK(svc >= 4, 1'b1)
        tick(70);
        scan_end(100);
        `CHK(n <= 3, 1'b1)
        `CHK(min_cycle_overrun_flag, 1'b1)
        `CHK(lastScanMs, 16'd7)
        start();
        `CHK(min_cycle_overrun_flag, 1'b0)
    endtask

    // main sequence
    initial begin
        {srst, programStart, programStop, progToMonitor, scanDone, serialReq, periphReq} = 7'h01 << 6;
        {forced_state_retain_flag, io_memory_retain_flag} = 2'b00;
        bus = '0;
        rawInputs = 16'h0000;
        tick(20);
        srst = 1'b0;
        tick(1);
        t_latch();
        t_settle();
        t_defaults();
        t_retain();
        t_scan();
        complete_run();
    end
endmodule
